// ===== logic/trcf_fifo.sv
// Octet FIFO with a registered output stage.
`timescale 1ns/1ps
module trcf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             clock_in,
    input  wire logic             resetn_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;

    // ------------------------------------------------------------------
    // Handshake terms
    // ------------------------------------------------------------------
    // The output register adds one word of slack beyond DEPTH.
    wire ring_push = in_valid_in && in_ready_out;
    wire ring_pop  = (count != '0) && (!out_valid_out || out_ready_in);
    assign in_ready_out = (count != (PW+1)'(DEPTH));

    // Ring storage, written only, never reset, as it holds data.
    always_ff @(posedge clock_in)
    begin
        if (ring_push)
            mem[wr_ptr] <= in_data_in;
    end

    // Pointers and fill level.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (ring_push)
                wr_ptr <= wr_ptr + 1'b1;
            if (ring_pop)
                rd_ptr <= rd_ptr + 1'b1;
            count <= count + (PW+1)'(ring_push) - (PW+1)'(ring_pop);
        end
    end

    // Output stage so the sink sees flip-flops only.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            out_valid_out <= 1'b0;
            out_data_out  <= '0;
        end
        else if (ring_pop)
        begin
            out_valid_out <= 1'b1;
            out_data_out  <= mem[rd_ptr];
        end
        else if (out_ready_in)
            out_valid_out <= 1'b0;
    end
endmodule : trcf_fifo

// ===== logic/trcf_framer.sv
// Framer for the rebuild outcome message sent to the domain master.
`timescale 1ns/1ps
module trcf_framer (
    input  wire logic                  clock_in,
    input  wire logic                  resetn_in,
    input  wire logic                  req_valid_in,
    input  wire trcf_pkg::trcf_req_t   req_in,
    output logic                       req_ready_out,
    input  wire logic                  relay_confirm_in,
    input  wire logic                  entry_we_in,
    input  wire logic [2:0]            entry_idx_in,
    input  wire trcf_pkg::trcf_entry_t entry_in,
    output logic                       out_valid_out,
    input  wire logic                  out_ready_in,
    output logic [7:0]                 out_data_out,
    output logic                       out_last_out
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    trcf_pkg::trcf_state_t state;
    trcf_pkg::trcf_state_t next_state;
    trcf_pkg::trcf_req_t   req;
    trcf_pkg::trcf_entry_t tbl_rd;
    trcf_pkg::trcf_item_t  cur_item;
    trcf_pkg::trcf_item_t  fifo_q;
    logic [2:0]            hdr_idx;
    logic [2:0]            ent_idx;
    logic [1:0]            sub;
    logic                  conf_seen;
    logic                  fifo_in_ready;
    logic [4:0]            pos;

    // ------------------------------------------------------------------
    // Request capture terms
    // ------------------------------------------------------------------
    // Oversized counts are clipped to the table so the frame stays consistent.
    wire       take_req  = (state == trcf_pkg::ST_IDLE) && req_valid_in;
    wire       in_succ   = (req_in.outcome == trcf_pkg::OUTCOME_SUCCESS);
    wire [7:0] clip_cnt  = (req_in.relay_count > trcf_pkg::MAX_COUNT)
                         ? trcf_pkg::MAX_COUNT : req_in.relay_count;
    wire [7:0] cap_cnt   = in_succ ? clip_cnt : 8'h00;

    // ------------------------------------------------------------------
    // Frame shape decode
    // ------------------------------------------------------------------
    wire       is_succ   = (req.outcome == trcf_pkg::OUTCOME_SUCCESS);
    wire       is_bidir  = (req.flow_type == trcf_pkg::FLOW_BI);
    wire       has_ent   = is_succ && (req.relay_count != 8'h00);
    wire       hdr_done  = (hdr_idx == trcf_pkg::HDR_LAST_IDX);
    wire       sub_done  = is_bidir ? (sub == trcf_pkg::SUB_REV)
                                    : (sub == trcf_pkg::SUB_FLOW);
    wire       ent_last  = ({5'h00, ent_idx} == (req.relay_count - 8'h01));
    wire       ent_done  = sub_done && ent_last;
    wire       emitting  = (state == trcf_pkg::ST_HEADER)
                        || (state == trcf_pkg::ST_ENTRY)
                        || (state == trcf_pkg::ST_FAIL);
    wire       push      = emitting && fifo_in_ready;
    wire       conf_take = (state == trcf_pkg::ST_WAIT_CONF) && conf_seen;

    // ------------------------------------------------------------------
    // Octet selection
    // ------------------------------------------------------------------
    // Header octets in payload order; octet 4 has no field and goes out as zero.
    wire [7:0] hdr_byte =
        (hdr_idx == 3'h0) ? req.originator :
        (hdr_idx == 3'h1) ? req.flow :
        (hdr_idx == 3'h2) ? req.outcome :
        (hdr_idx == 3'h3) ? req.endpoint :
        (hdr_idx == 3'h4) ? trcf_pkg::PAD_OCTET :
        (hdr_idx == 3'h5) ? req.flow_type :
        req.relay_count;

    // Entry octets: node, forward flow, then reverse flow on bidirectional flows only.
    wire [7:0] ent_byte =
        (sub == trcf_pkg::SUB_NODE) ? tbl_rd.node :
        (sub == trcf_pkg::SUB_FLOW) ? tbl_rd.flow :
        tbl_rd.rev_flow;

    // A failure frame ends with the failing node in place of the entries.
    // One assignment fills the whole item so the struct has a single driver.
    wire [7:0] item_data =
        (state == trcf_pkg::ST_HEADER) ? hdr_byte :
        (state == trcf_pkg::ST_ENTRY)  ? ent_byte :
        req.fail_node;
    wire       item_last =
        ((state == trcf_pkg::ST_HEADER) && hdr_done && is_succ && !has_ent)
        || ((state == trcf_pkg::ST_ENTRY) && ent_done)
        || (state == trcf_pkg::ST_FAIL);
    assign cur_item = '{data: item_data, last: item_last};

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Header output waits for the first relay's confirmation.
    always_comb
    begin
        next_state = state;
        case (state)
            trcf_pkg::ST_IDLE:
                if (req_valid_in)
                    next_state = trcf_pkg::ST_WAIT_CONF;
            trcf_pkg::ST_WAIT_CONF:
                if (conf_seen)
                    next_state = trcf_pkg::ST_HEADER;
            trcf_pkg::ST_HEADER:
                if (push && hdr_done)
                begin
                    if (!is_succ)
                        next_state = trcf_pkg::ST_FAIL;
                    else if (has_ent)
                        next_state = trcf_pkg::ST_ENTRY;
                    else
                        next_state = trcf_pkg::ST_IDLE;
                end
            trcf_pkg::ST_ENTRY:
                if (push && ent_done)
                    next_state = trcf_pkg::ST_IDLE;
            trcf_pkg::ST_FAIL:
                if (push)
                    next_state = trcf_pkg::ST_IDLE;
            default:
                next_state = trcf_pkg::ST_IDLE;
        endcase
    end

    // State register and the ready flag, which tracks the idle state in the same cycle, except after reset, where it loads low.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state         <= trcf_pkg::ST_IDLE;
            req_ready_out <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            req_ready_out <= (next_state == trcf_pkg::ST_IDLE);
        end
    end

    // Latched request; the count is forced to zero on any failure outcome.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            req <= '0;
        else if (take_req)
        begin
            req             <= req_in;
            req.relay_count <= cap_cnt;
        end
    end

    // A confirmation pulse in the cycle it is consumed survives for the next frame.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            conf_seen <= 1'b0;
        else
            conf_seen <= relay_confirm_in || (conf_seen && !conf_take);
    end

    // Octet and entry walkers; a stalled FIFO freezes them.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            hdr_idx <= 3'h0;
            ent_idx <= 3'h0;
            sub     <= trcf_pkg::SUB_NODE;
        end
        else if (take_req)
        begin
            hdr_idx <= 3'h0;
            ent_idx <= 3'h0;
            sub     <= trcf_pkg::SUB_NODE;
        end
        else if (push && (state == trcf_pkg::ST_HEADER) && !hdr_done)
            hdr_idx <= hdr_idx + 3'h1;
        else if (push && (state == trcf_pkg::ST_ENTRY))
        begin
            sub <= sub_done ? trcf_pkg::SUB_NODE : sub + 2'h1;
            if (sub_done)
                ent_idx <= ent_idx + 3'h1;
        end
    end

    // Payload position of the next octet, used by the checks below.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            pos <= 5'h00;
        else if (push)
            pos <= cur_item.last ? 5'h00 : pos + 5'h01;
    end

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    trcf_relay_table #(
        .DEPTH (trcf_pkg::MAX_RELAYS),
        .IDX_W (trcf_pkg::IDX_W)
    ) trcf_relay_table_i (
        .clock_in    (clock_in),
        .resetn_in   (resetn_in),
        .wr_en_in    (entry_we_in),
        .wr_idx_in   (entry_idx_in),
        .wr_data_in  (entry_in),
        .rd_idx_in   (ent_idx),
        .rd_data_out (tbl_rd)
    );

    // The FIFO decouples the sink; when it fills, the walkers stall.
    trcf_fifo #(
        .WIDTH (trcf_pkg::ITEM_W),
        .DEPTH (trcf_pkg::FIFO_DEPTH)
    ) trcf_fifo_i (
        .clock_in      (clock_in),
        .resetn_in     (resetn_in),
        .in_valid_in   (emitting),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (cur_item),
        .out_valid_out (out_valid_out),
        .out_ready_in  (out_ready_in),
        .out_data_out  (fifo_q)
    );

    assign out_data_out = fifo_q.data;
    assign out_last_out = fifo_q.last;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);

    wire [4:0] stride = is_bidir ? 5'h03 : 5'h02;
    wire [4:0] ent_base = 5'(stride * {2'h0, ent_idx});

    conf_gate_a: assert property ($rose(state == trcf_pkg::ST_HEADER) |-> $past(conf_seen))
        else $error("Header started without relay confirmation.");
    wait_hold_a: assert property (state == trcf_pkg::ST_WAIT_CONF && !conf_seen |=> state == trcf_pkg::ST_WAIT_CONF)
        else $error("Frame left the wait state without a confirmation.");
    orig_octet_a: assert property (push && pos == trcf_pkg::OFS_ORIGINATOR |->
        cur_item.data == req.originator && state == trcf_pkg::ST_HEADER)
        else $error("Octet 0 is not the originator.");
    flow_octet_a: assert property (push && pos == trcf_pkg::OFS_FLOW |-> cur_item.data == req.flow)
        else $error("Octet 1 is not the flow identifier.");
    outcome_octet_a: assert property (push && pos == trcf_pkg::OFS_OUTCOME |-> cur_item.data == req.outcome)
        else $error("Octet 2 is not the outcome.");
    endpoint_octet_a: assert property (push && pos == trcf_pkg::OFS_ENDPOINT |-> cur_item.data == req.endpoint)
        else $error("Octet 3 is not the endpoint.");
    pad_octet_a: assert property (push && pos == trcf_pkg::OFS_PAD |-> cur_item.data == trcf_pkg::PAD_OCTET)
        else $error("Octet 4 is not zero.");
    type_octet_a: assert property (push && pos == trcf_pkg::OFS_FLOW_TYPE |-> cur_item.data == req.flow_type)
        else $error("Octet 5 is not the flow type.");
    count_zero_a: assert property (push && pos == trcf_pkg::OFS_COUNT && !is_succ |-> cur_item.data == 8'h00)
        else $error("Relay count not zero on failure.");
    count_fit_a: assert property (push && pos == trcf_pkg::OFS_COUNT |-> cur_item.data <= trcf_pkg::MAX_COUNT)
        else $error("Relay count exceeds the table.");
    entry_node_a: assert property (push && state == trcf_pkg::ST_ENTRY && sub == trcf_pkg::SUB_NODE |->
        pos == trcf_pkg::OFS_ENTRY_NODE + ent_base)
        else $error("Relay node octet misplaced.");
    entry_flow_a: assert property (push && state == trcf_pkg::ST_ENTRY && sub == trcf_pkg::SUB_FLOW |->
        pos == trcf_pkg::OFS_ENTRY_FLOW + ent_base)
        else $error("Relay flow octet misplaced.");
    entry_rev_a: assert property (push && state == trcf_pkg::ST_ENTRY && sub == trcf_pkg::SUB_REV |->
        pos == trcf_pkg::OFS_ENTRY_REV + ent_base && is_bidir)
        else $error("Reverse flow octet misplaced.");
    rev_only_bi_a: assert property (push && state == trcf_pkg::ST_ENTRY && !is_bidir |->
        ##1 sub != trcf_pkg::SUB_REV)
        else $error("Reverse flow sent on unidirectional flow.");
    entry_succ_a: assert property (state == trcf_pkg::ST_ENTRY |-> is_succ)
        else $error("Relay entries on failure.");
    fail_node_a: assert property (push && state == trcf_pkg::ST_FAIL |-> pos == trcf_pkg::OFS_FAIL_NODE
        && cur_item.data == req.fail_node && cur_item.last)
        else $error("Failing node octet wrong.");
    fail_only_a: assert property (state == trcf_pkg::ST_FAIL |-> !is_succ)
        else $error("Failing node octet on success.");

    bidir_done_c: cover property (push && cur_item.last && state == trcf_pkg::ST_ENTRY && is_bidir);
    fail_done_c: cover property (push && state == trcf_pkg::ST_FAIL);
    stall_c: cover property (emitting && !fifo_in_ready);
    uni_done_c: cover property (push && cur_item.last && state == trcf_pkg::ST_ENTRY && !is_bidir);
    clip_c: cover property (take_req && req_in.relay_count > trcf_pkg::MAX_COUNT);
endmodule : trcf_framer

// ===== logic/trcf_pkg.sv
// Shared constants and types for the tunnel rebuild outcome framer.
package trcf_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int MAX_RELAYS = 8;
    localparam int IDX_W      = 3;
    localparam int FIFO_DEPTH = 16;
    localparam int ITEM_W     = 9;

    // ------------------------------------------------------------------
    // Octet offsets inside the management payload
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_ORIGINATOR = 5'h00;
    localparam logic [4:0] OFS_FLOW       = 5'h01;
    localparam logic [4:0] OFS_OUTCOME    = 5'h02;
    localparam logic [4:0] OFS_ENDPOINT   = 5'h03;
    localparam logic [4:0] OFS_PAD        = 5'h04;
    localparam logic [4:0] OFS_FLOW_TYPE  = 5'h05;
    localparam logic [4:0] OFS_COUNT      = 5'h06;
    localparam logic [4:0] OFS_ENTRY_NODE = 5'h07;
    localparam logic [4:0] OFS_ENTRY_FLOW = 5'h08;
    localparam logic [4:0] OFS_ENTRY_REV  = 5'h09;
    localparam logic [4:0] OFS_FAIL_NODE  = 5'h07;
    localparam logic [2:0] HDR_LAST_IDX   = 3'h6;

    // ------------------------------------------------------------------
    // Field codes, pad octet and count limit
    // ------------------------------------------------------------------
    localparam logic [7:0] OUTCOME_SUCCESS  = 8'h00;
    localparam logic [7:0] OUTCOME_CAPAB    = 8'h01;
    localparam logic [7:0] OUTCOME_RESOURCE = 8'h02;
    localparam logic [7:0] OUTCOME_LINK     = 8'h03;
    localparam logic [7:0] FLOW_UNI         = 8'h00;
    localparam logic [7:0] FLOW_BI          = 8'h01;
    localparam logic [7:0] PAD_OCTET        = 8'h00;
    localparam logic [7:0] MAX_COUNT        = 8'h08;
    localparam logic [1:0] SUB_NODE         = 2'h0;
    localparam logic [1:0] SUB_FLOW         = 2'h1;
    localparam logic [1:0] SUB_REV          = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] originator;
        logic [7:0] flow;
        logic [7:0] outcome;
        logic [7:0] endpoint;
        logic [7:0] flow_type;
        logic [7:0] relay_count;
        logic [7:0] fail_node;
    } trcf_req_t;

    typedef struct packed {
        logic [7:0] node;
        logic [7:0] flow;
        logic [7:0] rev_flow;
    } trcf_entry_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } trcf_item_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_CONF,
        ST_HEADER,
        ST_ENTRY,
        ST_FAIL
    } trcf_state_t;

endpackage : trcf_pkg

// ===== logic/trcf_relay_table.sv
// Indexed store of relay entry triples.
`timescale 1ns/1ps
module trcf_relay_table #(
    parameter int DEPTH = 8,
    parameter int IDX_W = 3
) (
    input  wire logic               clock_in,
    input  wire logic               resetn_in,
    input  wire logic               wr_en_in,
    input  wire logic [IDX_W-1:0]   wr_idx_in,
    input  wire trcf_pkg::trcf_entry_t wr_data_in,
    input  wire logic [IDX_W-1:0]   rd_idx_in,
    output trcf_pkg::trcf_entry_t   rd_data_out
);
    trcf_pkg::trcf_entry_t table_q [DEPTH];

    // Entries clear at reset so an unloaded slot reads as zero.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            for (int i = 0; i < DEPTH; i++)
                table_q[i] <= '0;
        end
        else if (wr_en_in)
            table_q[wr_idx_in] <= wr_data_in;
    end

    assign rd_data_out = table_q[rd_idx_in];
endmodule : trcf_relay_table

// ===== tb/trcf_framer_test.sv
// Self-checking testbench of the rebuild outcome framer.
`timescale 1ns/1ps
module trcf_framer_test;
    logic                  clock_in = 1'b0;
    logic                  resetn_in = 1'b0;
    logic                  req_valid_in = 1'b0;
    trcf_pkg::trcf_req_t   req_in = '0;
    logic                  relay_confirm_in = 1'b0;
    logic                  entry_we_in = 1'b0;
    logic [2:0]            entry_idx_in = 3'h0;
    trcf_pkg::trcf_entry_t entry_in = '0;
    logic                  req_ready_out, out_valid_out, out_ready_in, out_last_out, malformed;
    logic [7:0]            out_data_out;
    logic                  stall = 1'b0;
    logic                  hold = 1'b0;
    logic [7:0]            seed = 8'h44;
    logic [7:0]            stall_seed = 8'h44;
    logic [8:0]            exp_q[$];
    int                    error_cnt = 0;
    int                    total_checks = 0;
    int                    cycles = 0;
    logic [7:0]            tab[7][3] = '{'{8'h00, 8'h01, 8'h08}, '{8'h00, 8'h00, 8'h02}, '{8'h00, 8'h01, 8'h00},
                                         '{8'h01, 8'h00, 8'h05}, '{8'h02, 8'h01, 8'h03}, '{8'h03, 8'h00, 8'h08},
                                         '{8'h00, 8'h00, 8'h0b}};

    trcf_framer trcf_framer_i (.clock_in(clock_in), .resetn_in(resetn_in), .req_valid_in(req_valid_in),
        .req_in(req_in), .req_ready_out(req_ready_out), .relay_confirm_in(relay_confirm_in),
        .entry_we_in(entry_we_in), .entry_idx_in(entry_idx_in), .entry_in(entry_in),
        .out_valid_out(out_valid_out), .out_ready_in(out_ready_in), .out_data_out(out_data_out),
        .out_last_out(out_last_out));
    trcf_sink_model trcf_sink_model_i (.clock_in(clock_in), .resetn_in(resetn_in), .stall_in(stall),
        .valid_in(out_valid_out), .data_in(out_data_out), .last_in(out_last_out),
        .ready_out(out_ready_in), .malformed_out(malformed));

    // Clock of 50 ns period.
    always #25 clock_in = ~clock_in;

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    function automatic logic [7:0] rnd();
        seed = lfsr_next(seed);
        return seed;
    endfunction : rnd

    task automatic fail(input string msg);
        error_cnt++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask : fail

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // Random stalls on the sink, or a solid stall while hold is set, so the FIFO fills and refuses.
    always @(posedge clock_in)
    begin
        stall_seed <= lfsr_next(stall_seed);
        stall      <= hold | stall_seed[0];
    end

    // Hang guard: the seven frames need well under a thousand cycles.
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail("timeout");
            report_and_stop();
        end
    end

    // Every accepted octet is compared with the oldest expectation.
    always @(posedge clock_in)
    begin
        if (resetn_in && out_valid_out === 1'b1 && out_ready_in === 1'b1)
        begin
            total_checks++;
            if (exp_q.size() == 0)
                fail("octet beyond end of frame");
            else if ({out_data_out, out_last_out} !== exp_q.pop_front())
                fail("octet or end marker wrong");
        end
    end

    // One frame: fill the relay table, request, check silence once, ten cycles on, just before the confirm, then let it drain.
    task automatic send_frame(input logic [7:0] outc, input logic [7:0] ft, input logic [7:0] n, input logic stop);
        trcf_pkg::trcf_req_t   r;
        trcf_pkg::trcf_entry_t e[8];
        logic [7:0]            o[$];
        int                    i;
        logic                  ok;
        logic [7:0]            m;
        ok = (outc === trcf_pkg::OUTCOME_SUCCESS);
        m  = (n > trcf_pkg::MAX_COUNT) ? trcf_pkg::MAX_COUNT : n; // A count beyond the table is clipped.
        for (i = 0; i < m; i++)
        begin
            e[i] = {rnd(), rnd(), rnd()};
            @(posedge clock_in);
            entry_we_in  <= 1'b1;
            entry_idx_in <= i[2:0];
            entry_in     <= e[i];
        end
        @(posedge clock_in);
        entry_we_in <= 1'b0;
        r = '{rnd(), rnd(), outc, rnd(), ft, n, rnd()};
        o = {r.originator, r.flow, outc, r.endpoint, trcf_pkg::PAD_OCTET, ft, ok ? m : 8'h00};
        if (ok)
            for (i = 0; i < m; i++)
            begin
                o.push_back(e[i].node);
                o.push_back(e[i].flow);
                if (ft === trcf_pkg::FLOW_BI)
                    o.push_back(e[i].rev_flow);
            end
        else
            o.push_back(r.fail_node);
        foreach (o[k])
            exp_q.push_back({o[k], k == o.size() - 1});
        for (i = 0; i < 200 && req_ready_out !== 1'b1; i++)
            @(posedge clock_in);
        req_valid_in <= 1'b1;
        req_in       <= r;
        hold         <= stop;
        @(posedge clock_in);
        req_valid_in <= 1'b0;
        repeat (10) @(posedge clock_in);
        total_checks++;
        if (out_valid_out !== 1'b0)
            fail("frame left before the relay confirmation");
        relay_confirm_in <= 1'b1;
        @(posedge clock_in);
        relay_confirm_in <= 1'b0;
        if (stop)
        begin
            repeat (40) @(posedge clock_in);
            total_checks++;
            if (req_ready_out !== 1'b0)
                fail("framer idle while the stalled frame is unsent");
            hold <= 1'b0;
        end
        for (i = 0; i < 500 && exp_q.size() != 0; i++)
            @(posedge clock_in);
    endtask : send_frame

    // Reset for two cycles, then the table of frames: every outcome code, both flow types, a clipped count.
    initial
    begin
        repeat (2) @(posedge clock_in);
        resetn_in <= 1'b1;
        for (int t = 0; t < 7; t++)
        begin
            send_frame(tab[t][0], tab[t][1], tab[t][2], t == 0);
            $display("test %0d done", t);
        end
        repeat (5) @(posedge clock_in);
        total_checks++;
        if (exp_q.size() != 0 || malformed !== 1'b0)
            fail("octets missing or reserved code seen");
        report_and_stop();
    end
endmodule : trcf_framer_test

// ===== tb/trcf_sink_model.sv
// Sink model of the domain master parser that takes the framer's octet stream.
`timescale 1ns/1ps
module trcf_sink_model (
    input  wire logic       clock_in,
    input  wire logic       resetn_in,
    input  wire logic       stall_in,
    input  wire logic       valid_in,
    input  wire logic [7:0] data_in,
    input  wire logic       last_in,
    output logic            ready_out,
    output logic            malformed_out
);
    logic [4:0] idx;
    logic [7:0] outcome;
    logic [7:0] flow_type;
    logic [7:0] count;

    // A frame that ends before the octets its relay count declares is short.
    wire [4:0] stride      = (flow_type == 8'h01) ? 5'h03 : 5'h02;
    wire [4:0] need_idx    = (count == 8'h00) ? 5'h07 : 5'h06 + stride * count[4:0];
    wire       short_frame = last_in && ((idx < 5'h06)
                             || (idx == 5'h06 && (data_in != 8'h00 || outcome != 8'h00))
                             || (idx > 5'h06 && idx < need_idx));

    // Back-pressure comes straight from the bench so the FIFO can be driven full.
    assign ready_out = !stall_in;

    // Parser position and malformed flag for reserved codes and short frames; octet 4 is never examined.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            idx           <= 5'h00;
            outcome       <= 8'h00;
            flow_type     <= 8'h00;
            count         <= 8'h00;
            malformed_out <= 1'b0;
        end
        else if (valid_in && ready_out)
        begin
            idx <= last_in ? 5'h00 : idx + 5'h01;
            if (idx == 5'h02)
                outcome <= data_in;
            if (idx == 5'h05)
                flow_type <= data_in;
            if (idx == 5'h06)
                count <= data_in;
            if ((idx == 5'h02 && data_in > 8'h03) || (idx == 5'h05 && data_in > 8'h01) || short_frame)
                malformed_out <= 1'b1;
        end
    end
endmodule : trcf_sink_model
